// ==== kiu_pkg.sv ====
// Package with register map, field positions and reset values.
package kiu_pkg;

    // Register byte offsets on the bus.
    localparam logic [3:0] KIU_OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] KIU_OFS_PIN_ENABLES = 4'h4;
    localparam logic [3:0] KIU_OFS_POLARITY_SELECT = 4'h8;

    // Field positions in the status and control register.
    localparam int KIU_BIT_MODE = 0;
    localparam int KIU_BIT_IRQ_ENABLE = 1;
    localparam int KIU_BIT_ACK = 2;
    localparam int KIU_BIT_FLAG = 3;

    // Implemented key pins: bits 5, 4, 2, 1 and 0.
    localparam logic [7:0] KIU_PIN_MASK = 8'h37;

    // Reset values.
    localparam logic [7:0] KIU_RST_PIN_ENABLES = 8'h00;
    localparam logic [7:0] KIU_RST_POLARITY = 8'h00;
    localparam logic KIU_RST_MODE = 1'b0;
    localparam logic KIU_RST_IRQ_ENABLE = 1'b0;
    localparam logic KIU_RST_FLAG = 1'b0;

    // Register width and bus data width.
    localparam int KIU_REG_W = 8;
    localparam int KIU_BUS_W = 32;

    // Bus handshake states.
    typedef enum logic [0:0] {
        KIU_BUS_IDLE,
        KIU_BUS_ANSWER
    } kiu_bus_state_t;

endpackage

// ==== kiu_pin_detect.sv ====
// Key pin synchroniser with edge and level detection.
`timescale 1ns/10ps
`default_nettype none
module kiu_pin_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Raw pins and configuration
    input wire logic [WIDTH-1:0] pins_i,
    input wire logic [WIDTH-1:0] enables_i,
    input wire logic [WIDTH-1:0] polarity_i,
    // Detection results
    output logic [WIDTH-1:0] edge_o,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;
    logic [WIDTH-1:0] prev_q, prev_d;
    logic [WIDTH-1:0] now_asserted;
    logic [WIDTH-1:0] prev_asserted;

    always_comb begin
        meta_d = pins_i;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // A polarity bit of 0 asserts on low, 1 asserts on high.
    always_comb begin
        now_asserted = ~(sync_q ^ polarity_i);
        prev_asserted = ~(prev_q ^ polarity_i);
        edge_o = enables_i & now_asserted & ~prev_asserted;
        level_o = enables_i & now_asserted;
    end

endmodule // kiu_pin_detect
`default_nettype wire

// ==== kiu_top.sv ====
// Keyboard interrupt unit with Avalon-MM register access.
//
// Functional notes
// - Each implemented pin (5, 4, 2, 1, 0) has its own enable bit.
// - Mode bit 0 selects edge-only (0) or edge-and-level (1) sensing.
// - Each pin's polarity chooses falling/low or rising/high sensing.
// - Flag bit 3 is set by detection; writes to bit 3 cannot change it.
// - Writing 1 to bit 2 requests a flag clear; bit 2 reads 0.
// - Interrupt request shows only while enable bit 1 and flag are set.
// - All enabled pins merge into one software-maskable request line.
// - Detection continues in wait mode; events wake the processor.
// - Pin events with interrupt enabled raise the wake output.
// - The unit never freezes in background debug mode.
// - Three 8-bit registers: status/control, pin enables, polarity.
// - An edge is deasserted in one bus cycle then asserted the next.
// - Edge-only mode: edges set the flag; acknowledge clears it.
// - Level mode: acknowledge clears only if all enabled pins deasserted.
// - Polarity 0 means falling edge or low; 1 means rising or high.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module kiu_top
    import kiu_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [KIU_BUS_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [KIU_BUS_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Key pins
    input wire logic [KIU_REG_W-1:0] key_input_pin_i,
    // Interrupt and wake-up
    output logic irq_o,
    output logic wake_o
);

    // Bus handshake state.
    kiu_bus_state_t bus_state_q, bus_state_d;
    logic waitrequest_q, waitrequest_d;
    logic [KIU_BUS_W-1:0] readdata_q, readdata_d;

    // Software-visible state.
    logic [KIU_REG_W-1:0] key_pin_enables_q, key_pin_enables_d;
    logic [KIU_REG_W-1:0] key_polarity_select_q, key_polarity_select_d;
    logic detect_mode_select_q, detect_mode_select_d;
    logic key_irq_enable_q, key_irq_enable_d;
    logic key_event_flag_q, key_event_flag_d;

    // Output registers.
    logic irq_q, irq_d;
    logic wake_q, wake_d;

    // Detection results.
    logic [KIU_REG_W-1:0] pin_edge;
    logic [KIU_REG_W-1:0] pin_level;

    // Decoded bus and pin events.
    logic bus_request;
    logic bus_accept;
    logic write_accept;
    logic low_lane_write;
    logic key_flag_ack;
    logic set_event;
    logic any_asserted;
    logic clear_allowed;

    // Reads back one register, unmapped offsets read as zero.
    function automatic logic [KIU_BUS_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input logic [KIU_REG_W-1:0] status,
        input logic [KIU_REG_W-1:0] enables,
        input logic [KIU_REG_W-1:0] polarity
    );
        logic [KIU_BUS_W-1:0] value;
        value = '0;
        if (addr == ADDR_W'(KIU_OFS_STATUS_CONTROL)) begin
            value[KIU_REG_W-1:0] = status;
        end else if (addr == ADDR_W'(KIU_OFS_PIN_ENABLES)) begin
            value[KIU_REG_W-1:0] = enables;
        end else if (addr == ADDR_W'(KIU_OFS_POLARITY_SELECT)) begin
            value[KIU_REG_W-1:0] = polarity;
        end
        return value;
    endfunction

    // Assembles the status and control byte.
    function automatic logic [KIU_REG_W-1:0] status_byte(
        input logic flag,
        input logic irq_en,
        input logic mode
    );
        logic [KIU_REG_W-1:0] value;
        value = '0;
        value[KIU_BIT_FLAG] = flag;
        value[KIU_BIT_ACK] = 1'b0;
        value[KIU_BIT_IRQ_ENABLE] = irq_en;
        value[KIU_BIT_MODE] = mode;
        return value;
    endfunction

    // Pins sampled on the bus clock, never frozen.
    kiu_pin_detect #(
        .WIDTH(KIU_REG_W)
    ) u_pin_detect (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pins_i(key_input_pin_i),
        .enables_i(key_pin_enables_q),
        .polarity_i(key_polarity_select_q),
        .edge_o(pin_edge),
        .level_o(pin_level)
    );

    // Bus decode: a request is accepted at the edge where waitrequest is low.
    always_comb begin
        bus_request = avs_read_i | avs_write_i;
        bus_accept = bus_request & ~waitrequest_q;
        write_accept = avs_write_i & ~waitrequest_q;
        low_lane_write = write_accept & avs_byteenable_i[0];
    end

    // Bus handshake: one wait cycle, then one answer cycle.
    always_comb begin
        bus_state_d = bus_state_q;
        waitrequest_d = 1'b1;
        readdata_d = readdata_q;
        unique case (bus_state_q)
            KIU_BUS_IDLE: begin
                if (bus_request) begin
                    bus_state_d = KIU_BUS_ANSWER;
                    waitrequest_d = 1'b0;
                    readdata_d = read_mux(avs_address_i,
                        status_byte(key_event_flag_q, key_irq_enable_q,
                            detect_mode_select_q),
                        key_pin_enables_q,
                        key_polarity_select_q);
                end
            end
            KIU_BUS_ANSWER: begin
                bus_state_d = KIU_BUS_IDLE;
                waitrequest_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_state_q <= KIU_BUS_IDLE;
            waitrequest_q <= 1'b1;
            readdata_q <= '0;
        end else begin
            bus_state_q <= bus_state_d;
            waitrequest_q <= waitrequest_d;
            readdata_q <= readdata_d;
        end
    end

    // Register writes; only the low byte lane carries the 8-bit registers.
    always_comb begin
        key_pin_enables_d = key_pin_enables_q;
        key_polarity_select_d = key_polarity_select_q;
        detect_mode_select_d = detect_mode_select_q;
        key_irq_enable_d = key_irq_enable_q;
        key_flag_ack = 1'b0;
        if (low_lane_write) begin
            if (avs_address_i == ADDR_W'(KIU_OFS_STATUS_CONTROL)) begin
                detect_mode_select_d =
                    avs_writedata_i[KIU_BIT_MODE];
                key_irq_enable_d =
                    avs_writedata_i[KIU_BIT_IRQ_ENABLE];
                key_flag_ack = avs_writedata_i[KIU_BIT_ACK];
            end else if (avs_address_i == ADDR_W'(KIU_OFS_PIN_ENABLES)) begin
                key_pin_enables_d =
                    avs_writedata_i[KIU_REG_W-1:0] & KIU_PIN_MASK;
            end else if (avs_address_i ==
                    ADDR_W'(KIU_OFS_POLARITY_SELECT)) begin
                key_polarity_select_d =
                    avs_writedata_i[KIU_REG_W-1:0] & KIU_PIN_MASK;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            key_pin_enables_q <= KIU_RST_PIN_ENABLES;
            key_polarity_select_q <= KIU_RST_POLARITY;
            detect_mode_select_q <= KIU_RST_MODE;
            key_irq_enable_q <= KIU_RST_IRQ_ENABLE;
        end else begin
            key_pin_enables_q <= key_pin_enables_d;
            key_polarity_select_q <= key_polarity_select_d;
            detect_mode_select_q <= detect_mode_select_d;
            key_irq_enable_q <= key_irq_enable_d;
        end
    end

    // Flag: set by any enabled pin event, cleared by acknowledge.
    always_comb begin
        any_asserted = |pin_level;
        set_event = (|pin_edge) |
            (detect_mode_select_q & any_asserted);
        clear_allowed = ~detect_mode_select_q | ~any_asserted;
        key_event_flag_d = key_event_flag_q;
        if (key_flag_ack & clear_allowed) begin
            key_event_flag_d = 1'b0;
        end
        if (set_event) begin
            key_event_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            key_event_flag_q <= KIU_RST_FLAG;
        end else begin
            key_event_flag_q <= key_event_flag_d;
        end
    end

    // Request and wake outputs, registered.
    always_comb begin
        irq_d = key_event_flag_q & key_irq_enable_q;
        wake_d = key_event_flag_q & key_irq_enable_q;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            wake_q <= wake_d;
        end
    end

    assign avs_readdata_o = readdata_q;
    assign avs_waitrequest_o = waitrequest_q;
    assign irq_o = irq_q;
    assign wake_o = wake_q;

endmodule // kiu_top
`default_nettype wire

// ==== kiu_monitor.sv ====
// Checker of the keyboard interrupt unit port behaviour.
`timescale 1ns/10ps
`default_nettype none
module kiu_monitor
    import kiu_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Bus
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [KIU_BUS_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [KIU_BUS_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins and requests
    input wire logic [KIU_REG_W-1:0] key_input_pin_i,
    input wire logic irq_o,
    input wire logic wake_o
);
    logic ie_q;
    logic ie_d;
    logic rd_ok;
    logic wr_st;
    logic [3:0] adr;
    assign adr = 4'(avs_address_i);
    assign rd_ok = avs_read_i && !avs_waitrequest_o;
    assign wr_st = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && adr == KIU_OFS_STATUS_CONTROL;
    always_comb ie_d = wr_st ? avs_writedata_i[KIU_BIT_IRQ_ENABLE] : ie_q;
    always_ff @(posedge clock_i) ie_q <= srst_i ? 1'b0 : ie_d;
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    property p_wait_one;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer");
    property p_wait_stands;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_stands: assert property (p_wait_stands) else $error("long answer");
    property p_rd_upper;
        rd_ok |-> avs_readdata_o[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper data set");
    property p_ack_zero;
        rd_ok && adr == KIU_OFS_STATUS_CONTROL |->
            avs_readdata_o[7:4] == 4'h0 && !avs_readdata_o[KIU_BIT_ACK];
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("status bits");
    property p_pin_mask;
        rd_ok && (adr == KIU_OFS_PIN_ENABLES || adr == KIU_OFS_POLARITY_SELECT)
            |-> (avs_readdata_o[7:0] & ~KIU_PIN_MASK) == 8'h00;
    endproperty
    a_pin_mask: assert property (p_pin_mask) else $error("bad pin bit");
    property p_unmapped;
        rd_ok && adr != KIU_OFS_STATUS_CONTROL && adr != KIU_OFS_PIN_ENABLES
            && adr != KIU_OFS_POLARITY_SELECT |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_irq_off;
        wr_st && !avs_writedata_i[KIU_BIT_IRQ_ENABLE] |-> ##2 !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not masked");
    property p_irq_ie;
        $rose(irq_o) |-> $past(ie_q);
    endproperty
    a_irq_ie: assert property (p_irq_ie) else $error("irq while masked");
    property p_wake;
        wake_o == irq_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake differs");
    property p_reset;
        $fell(srst_i) |-> !irq_o && !wake_o && avs_waitrequest_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
endmodule // kiu_monitor
bind kiu_top kiu_monitor #(.ADDR_W(ADDR_W)) u_kiu_monitor (
    .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .key_input_pin_i(key_input_pin_i), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// ==== kiu_key_model.sv ====
// Key switch model driving the raw key pins.
`timescale 1ns/10ps
`default_nettype none
module kiu_key_model (
    // Clock
    input wire logic clock_i,
    // Wanted key levels and driven pins
    input wire logic [7:0] level_i,
    output logic [7:0] pins_o
);
    logic spin_q = 1'b0;
    // Unused pins change every cycle so the unit must ignore them.
    always_ff @(posedge clock_i) begin
        spin_q <= ~spin_q;
        pins_o <= {spin_q, spin_q, level_i[5:4], ~spin_q, level_i[2:0]};
    end
endmodule // kiu_key_model
`default_nettype wire

// ==== testbench.sv ====
// Register level testbench of the keyboard interrupt unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import kiu_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wreq;
    logic [7:0] keys = 8'h01;
    logic [3:0] be = 4'h1;
    logic [7:0] pins;
    logic irq;
    logic wake;
    int err_count = 0;
    int compares = 0;
    kiu_key_model u_kiu_key_model (.clock_i(clock_i), .level_i(keys),
        .pins_o(pins));
    kiu_top u_kiu_top (.clock_i(clock_i), .srst_i(srst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .key_input_pin_i(pins), .irq_o(irq),
        .wake_o(wake));
    initial forever #2 clock_i = ~clock_i;
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clock_i);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {24'h0, d};
        @(posedge clock_i);
        while (wreq !== 1'b0) @(posedge clock_i);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wt(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        cmp(q, exp);
    endtask
    task automatic key(input logic [7:0] v);
        @(posedge clock_i);
        keys <= v;
        repeat (8) @(posedge clock_i);
    endtask
    task automatic irqc(input logic exp);
        repeat (4) @(posedge clock_i);
        cmp({6'h0, wake, irq}, {6'h0, exp, exp});
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        $display("CHECK FAILED %0t watchdog", $time);
        summarize();
    end
    initial begin
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        rc(4'h0, 8'h00);
        rc(4'h4, 8'h00);
        rc(4'h8, 8'h00);
        $display("test reset done");
        wt(4'h4, 8'hff);
        rc(4'h4, 8'h37);
        wt(4'h8, 8'hff);
        rc(4'h8, 8'h37);
        wt(4'hc, 8'h55);
        rc(4'hc, 8'h00);
        wt(4'h4, 8'h00);
        wt(4'h8, 8'h00);
        be <= 4'h0;
        wt(4'h4, 8'h01);
        rc(4'h4, 8'h00);
        be <= 4'h1;
        wt(4'h0, 8'h04);
        rc(4'h0, 8'h00);
        $display("test registers done");
        wt(4'h4, 8'h01);
        key(8'h00);
        rc(4'h0, 8'h08);
        irqc(1'b0);
        wt(4'h0, 8'h02);
        irqc(1'b1);
        wt(4'h0, 8'h0a);
        rc(4'h0, 8'h0a);
        wt(4'h0, 8'h06);
        rc(4'h0, 8'h02);
        irqc(1'b0);
        key(8'h02);
        key(8'h00);
        rc(4'h0, 8'h02);
        $display("test edge done");
        wt(4'h0, 8'h01);
        key(8'h00);
        rc(4'h0, 8'h09);
        wt(4'h0, 8'h05);
        rc(4'h0, 8'h09);
        key(8'h01);
        wt(4'h0, 8'h05);
        rc(4'h0, 8'h01);
        $display("test level done");
        wt(4'h0, 8'h00);
        wt(4'h4, 8'h20);
        wt(4'h8, 8'h20);
        wt(4'h0, 8'h04);
        rc(4'h0, 8'h00);
        key(8'h21);
        rc(4'h0, 8'h08);
        wt(4'h0, 8'h02);
        irqc(1'b1);
        wt(4'h0, 8'h00);
        irqc(1'b0);
        $display("test rising done");
        @(posedge clock_i);
        srst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        rc(4'h4, 8'h00);
        rc(4'h0, 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
